// ===== rtl/eag_pkg.sv
// Constants, types and helper functions of the effective address generator
package eag_pkg;
	localparam int ADDR_W = 32;
	localparam int VA_W = 40;
	localparam int PID_W = 8;
	localparam int EPN_W = 22;
	localparam int PAGE_SH = 10;
	localparam int SIZE_W = 3;
	localparam int IMM_W = 16;
	localparam int DISP_W = 26;
	localparam int RBASE_W = 5;
	localparam int TLB_IDX_W = 3;
	localparam int BUS_AW = 8;
	localparam logic [ADDR_W-1:0] INSN_BYTES = 32'h00000004;
	localparam logic [ADDR_W-1:0] WORD_ALIGN = 32'hFFFFFFFC;
	localparam logic [BUS_AW-1:0] REG_MACHINE_STATE = 8'h00;
	localparam logic [BUS_AW-1:0] REG_PROCESS_ID = 8'h04;
	localparam logic [BUS_AW-1:0] REG_TLB_INDEX = 8'h08;
	localparam logic [BUS_AW-1:0] REG_TLB_TAG = 8'h0C;
	localparam logic [BUS_AW-1:0] REG_TLB_DATA = 8'h10;
	localparam logic [BUS_AW-1:0] REG_TLB_RD_TAG = 8'h14;
	localparam logic [BUS_AW-1:0] REG_TLB_RD_DATA = 8'h18;
	localparam logic [BUS_AW-1:0] REG_STATUS = 8'h1C;
	localparam logic [BUS_AW-1:0] REG_MISS_ADDR = 8'h20;
	localparam int MSR_FETCH_BIT = 0;
	localparam int MSR_DATA_BIT = 1;
	localparam int MSR_USER_BIT = 2;
	localparam logic MSR_USER_RST = 1'b0;
	localparam logic MSR_RELOC_RST = 1'b0;
	localparam int TAG_VALID_BIT = 31;
	localparam int TAG_SIZE_LSB = 22;
	localparam int DATA_TID_LSB = 22;
	localparam int ST_MISS_BIT = 0;
	localparam int ST_PRIV_BIT = 1;
	typedef enum logic [1:0] {DF_BASE, DF_BASE_IMM, DF_BASE_INDEX} eag_data_form_e;
	typedef enum logic [2:0] {FF_SEQ, FF_REL, FF_ABS, FF_LINK, FF_COUNT} eag_fetch_form_e;
	typedef struct packed {
		logic valid;
		logic [SIZE_W-1:0] size;
		logic [EPN_W-1:0] epn;
		logic [PID_W-1:0] tid;
		logic [EPN_W-1:0] rpn;
	} eag_tlb_entry_s;

	// Carry out of the top bit is dropped, so addresses wrap to zero
	function automatic logic [ADDR_W-1:0] ea_add(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		ea_add = a + b;
	endfunction

	function automatic logic [ADDR_W-1:0] sext_imm(input logic [IMM_W-1:0] v);
		sext_imm = {{(ADDR_W-IMM_W){v[IMM_W-1]}}, v};
	endfunction

	function automatic logic [ADDR_W-1:0] sext_disp(input logic [DISP_W-1:0] v);
		sext_disp = {{(ADDR_W-DISP_W){v[DISP_W-1]}}, v};
	endfunction

	// Page size grows by four per size step, starting at 1 KB
	function automatic logic [EPN_W-1:0] page_mask(input logic [SIZE_W-1:0] s);
		page_mask = ~((22'h000001 << {s, 1'b0}) - 22'h000001);
	endfunction

	function automatic logic tlb_match(input eag_tlb_entry_s e, input logic [PID_W-1:0] pid,
		input logic [ADDR_W-1:0] ea);
		tlb_match = e.valid && (e.tid == '0 || e.tid == pid) &&
			((ea[ADDR_W-1:PAGE_SH] & page_mask(e.size)) == (e.epn & page_mask(e.size)));
	endfunction

	function automatic logic [ADDR_W-1:0] tlb_phys(input eag_tlb_entry_s e, input logic [ADDR_W-1:0] ea);
		logic [EPN_W-1:0] m;
		m = page_mask(e.size);
		tlb_phys = {(e.rpn & m) | (ea[ADDR_W-1:PAGE_SH] & ~m), ea[PAGE_SH-1:0]};
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		for (int i = 0; i < 4; i++)
		begin
			be_merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction
endpackage

// ===== rtl/eag_tlb.sv
// Software-loaded translation buffer with a registered read port
`timescale 1ns/10ps
module eag_tlb
#(
	parameter int IDX_W = eag_pkg::TLB_IDX_W
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_index,
	input wire eag_pkg::eag_tlb_entry_s wr_entry,
	input wire logic [IDX_W-1:0] rd_index,
	output eag_pkg::eag_tlb_entry_s rd_entry,
	input wire logic [eag_pkg::PID_W-1:0] lk_pid,
	input wire logic [eag_pkg::ADDR_W-1:0] lk_ea,
	output logic lk_hit,
	output logic [eag_pkg::ADDR_W-1:0] lk_pa
);
	import eag_pkg::*;
	localparam int ENTRIES = 1 << IDX_W;
	typedef struct packed {
		eag_tlb_entry_s [ENTRIES-1:0] ent;
		eag_tlb_entry_s rd;
	} eag_tlb_state_s;
	eag_tlb_state_s st_r;
	eag_tlb_state_s st_nxt;

	// Read port follows the written value so readback never shows a stale entry
	always_comb
	begin
		st_nxt = st_r;
		if (wr_en)
		begin
			st_nxt.ent[wr_index] = wr_entry;
		end
		st_nxt.rd = st_nxt.ent[rd_index];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_r <= '0;
		else if (ce)
			st_r <= st_nxt;
	end

	// Lowest matching entry wins; a miss is left to software, no table walk
	always_comb
	begin
		lk_hit = 1'b0;
		lk_pa = '0;
		for (int i = 0; i < ENTRIES; i++)
		begin
			if (!lk_hit && tlb_match(st_r.ent[i], lk_pid, lk_ea))
			begin
				lk_hit = 1'b1;
				lk_pa = tlb_phys(st_r.ent[i], lk_ea);
			end
		end
	end

	assign rd_entry = st_r.rd;
endmodule

// ===== rtl/eag_top.sv
// Effective address generator with relocation select, privilege check and register slave
// What this block does
// - Addresses are 32-bit unsigned binary sums
// - Base field zero means base value zero
// - Data forms: base, base+immediate, base+index
// - Sequential fetch is current address plus four
// - Branch: relative, absolute, link or count register
// - Branch targets have low two bits cleared
// - Carry out of top bit is dropped
// - Physical address presented is 32 bits wide
// - Virtual address is 40 bits wide
// - Fetch relocate bit selects real or virtual fetch
// - Data relocate bit selects real or virtual data
// - Fetch and data relocation chosen independently
// - No hardware page walk; software loads buffer
// - Variable pages, no segment or block translation
// - User mode restricts registers and instructions
// - User bit set means user; reset clears it
// - Privileged operation in user mode raises fault
// - Real mode passes effective address unchanged
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
module eag_top
#(
	parameter int TLB_IDX = eag_pkg::TLB_IDX_W
)
(
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CE,
	input wire logic [eag_pkg::BUS_AW-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic REQ_VALID,
	input wire logic REQ_IS_FETCH,
	input wire logic REQ_PRIVILEGED,
	input wire eag_pkg::eag_data_form_e DATA_FORM,
	input wire eag_pkg::eag_fetch_form_e FETCH_FORM,
	input wire logic [eag_pkg::RBASE_W-1:0] BASE_REG_FIELD,
	input wire logic [eag_pkg::ADDR_W-1:0] BASE_REG_VALUE,
	input wire logic [eag_pkg::ADDR_W-1:0] INDEX_REG_VALUE,
	input wire logic [eag_pkg::IMM_W-1:0] IMM_OFFSET,
	input wire logic [eag_pkg::DISP_W-1:0] BRANCH_DISP,
	input wire logic [eag_pkg::ADDR_W-1:0] CURRENT_FETCH_ADDRESS,
	input wire logic [eag_pkg::ADDR_W-1:0] LINK_RETURN_REGISTER,
	input wire logic [eag_pkg::ADDR_W-1:0] LOOP_COUNT_REGISTER,
	output logic ADDR_VALID,
	output logic ADDR_IS_FETCH,
	output logic [eag_pkg::ADDR_W-1:0] EFFECTIVE_ADDRESS,
	output logic [eag_pkg::VA_W-1:0] VIRTUAL_ADDRESS,
	output logic [eag_pkg::ADDR_W-1:0] PHYSICAL_ADDRESS,
	output logic TRANSLATED,
	output logic TLB_MISS,
	output logic PRIV_FAULT,
	output logic USER_MODE,
	output logic FETCH_RELOCATE,
	output logic DATA_RELOCATE
);
	import eag_pkg::*;

	typedef struct packed {
		logic fetch_relocate_bit;
		logic data_relocate_bit;
		logic user_mode_bit;
		logic [PID_W-1:0] pid;
		logic [TLB_IDX-1:0] tlb_index;
		logic [31:0] tlb_tag;
		logic bus_ack;
		logic [31:0] rdata;
		logic out_valid;
		logic out_fetch;
		logic [ADDR_W-1:0] ea;
		logic [VA_W-1:0] va;
		logic [ADDR_W-1:0] pa;
		logic translated;
		logic miss;
		logic priv_fault;
		logic miss_sticky;
		logic priv_sticky;
		logic [ADDR_W-1:0] miss_addr;
	} eag_state_s;

	eag_state_s st_r;
	eag_state_s st_nxt;
	logic [ADDR_W-1:0] base;
	logic [ADDR_W-1:0] data_ea;
	logic [ADDR_W-1:0] fetch_ea;
	logic [ADDR_W-1:0] req_ea;
	logic reloc;
	logic fault;
	logic lk_hit;
	logic [ADDR_W-1:0] lk_pa;
	logic bus_req;
	logic bus_done;
	logic [31:0] rd_img;
	logic [31:0] wv;
	logic tlb_we;
	eag_tlb_entry_s tlb_wr;
	eag_tlb_entry_s tlb_rd;

	// Address arithmetic: every sum on either path is a full 32-bit add, wrap on overflow
	always_comb
	begin
		base = (BASE_REG_FIELD == '0) ? '0 : BASE_REG_VALUE;
		case (DATA_FORM)
			DF_BASE: data_ea = base;
			DF_BASE_IMM: data_ea = ea_add(base, sext_imm(IMM_OFFSET));
			DF_BASE_INDEX: data_ea = ea_add(base, INDEX_REG_VALUE);
			default: data_ea = base;
		endcase
		case (FETCH_FORM)
			FF_SEQ: fetch_ea = ea_add(CURRENT_FETCH_ADDRESS, INSN_BYTES);
			FF_REL: fetch_ea = ea_add(CURRENT_FETCH_ADDRESS, sext_disp(BRANCH_DISP)) & WORD_ALIGN;
			FF_ABS: fetch_ea = sext_disp(BRANCH_DISP) & WORD_ALIGN;
			FF_LINK: fetch_ea = LINK_RETURN_REGISTER & WORD_ALIGN;
			FF_COUNT: fetch_ea = LOOP_COUNT_REGISTER & WORD_ALIGN;
			default: fetch_ea = ea_add(CURRENT_FETCH_ADDRESS, INSN_BYTES);
		endcase
		req_ea = REQ_IS_FETCH ? fetch_ea : data_ea;
		// Each access kind looks only at its own relocate bit
		reloc = REQ_IS_FETCH ? st_r.fetch_relocate_bit : st_r.data_relocate_bit;
		fault = REQ_PRIVILEGED && st_r.user_mode_bit;
	end

	eag_tlb #(
		.IDX_W(TLB_IDX)
	) u_tlb (
		.clk(SYS_CLK),
		.rst(RST),
		.ce(CE),
		.wr_en(tlb_we),
		.wr_index(st_r.tlb_index),
		.wr_entry(tlb_wr),
		.rd_index(st_nxt.tlb_index),
		.rd_entry(tlb_rd),
		.lk_pid(st_r.pid),
		.lk_ea(req_ea),
		.lk_hit(lk_hit),
		.lk_pa(lk_pa)
	);

	// Register image; read data is latched in the wait cycle and stands while waitrequest is low
	always_comb
	begin
		case (AVS_ADDRESS)
			REG_MACHINE_STATE: rd_img = {29'h0, st_r.user_mode_bit, st_r.data_relocate_bit, st_r.fetch_relocate_bit};
			REG_PROCESS_ID: rd_img = {24'h0, st_r.pid};
			REG_TLB_INDEX: rd_img = {{(32-TLB_IDX){1'b0}}, st_r.tlb_index};
			REG_TLB_TAG: rd_img = st_r.tlb_tag;
			REG_TLB_RD_TAG: rd_img = {tlb_rd.valid, 6'h00, tlb_rd.size, tlb_rd.epn};
			REG_TLB_RD_DATA: rd_img = {2'h0, tlb_rd.tid, tlb_rd.rpn};
			REG_STATUS: rd_img = {30'h0, st_r.priv_sticky, st_r.miss_sticky};
			REG_MISS_ADDR: rd_img = st_r.miss_addr;
			default: rd_img = 32'h00000000;
		endcase
		wv = be_merge(rd_img, AVS_WRITEDATA, AVS_BYTEENABLE);
		tlb_wr.valid = st_r.tlb_tag[TAG_VALID_BIT];
		tlb_wr.size = st_r.tlb_tag[TAG_SIZE_LSB +: SIZE_W];
		tlb_wr.epn = st_r.tlb_tag[EPN_W-1:0];
		tlb_wr.tid = wv[DATA_TID_LSB +: PID_W];
		tlb_wr.rpn = wv[EPN_W-1:0];
	end

	assign bus_req = AVS_READ || AVS_WRITE;
	assign bus_done = bus_req && st_r.bus_ack && CE;
	assign tlb_we = bus_done && AVS_WRITE && AVS_ADDRESS == REG_TLB_DATA;
	assign AVS_WAITREQUEST = bus_req && !(st_r.bus_ack && CE);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.bus_ack = bus_req && !st_r.bus_ack;
		if (bus_req && !st_r.bus_ack)
		begin
			st_nxt.rdata = rd_img;
		end
		if (bus_done && AVS_WRITE)
		begin
			case (AVS_ADDRESS)
				REG_MACHINE_STATE:
				begin
					st_nxt.fetch_relocate_bit = wv[MSR_FETCH_BIT];
					st_nxt.data_relocate_bit = wv[MSR_DATA_BIT];
					st_nxt.user_mode_bit = wv[MSR_USER_BIT];
				end
				REG_PROCESS_ID: st_nxt.pid = wv[PID_W-1:0];
				REG_TLB_INDEX: st_nxt.tlb_index = wv[TLB_IDX-1:0];
				REG_TLB_TAG: st_nxt.tlb_tag = wv;
				REG_STATUS:
				begin
					if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[ST_MISS_BIT])
						st_nxt.miss_sticky = 1'b0;
					if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[ST_PRIV_BIT])
						st_nxt.priv_sticky = 1'b0;
				end
				default: st_nxt.pid = st_r.pid;
			endcase
		end
		// Result stage: a fault or a miss withholds the address from memory
		st_nxt.out_valid = REQ_VALID && !fault && !(reloc && !lk_hit);
		st_nxt.priv_fault = REQ_VALID && fault;
		st_nxt.miss = REQ_VALID && !fault && reloc && !lk_hit;
		if (REQ_VALID)
		begin
			st_nxt.out_fetch = REQ_IS_FETCH;
			st_nxt.ea = req_ea;
			st_nxt.va = {st_r.pid, req_ea};
			st_nxt.translated = reloc;
			st_nxt.pa = reloc ? (lk_hit ? lk_pa : '0) : req_ea;
		end
		// Set after clear, so an event in the clearing cycle is kept
		if (st_nxt.miss)
		begin
			st_nxt.miss_sticky = 1'b1;
			st_nxt.miss_addr = req_ea;
		end
		if (st_nxt.priv_fault)
			st_nxt.priv_sticky = 1'b1;
	end

	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			st_r <= '0;
			st_r.user_mode_bit <= MSR_USER_RST;
			st_r.fetch_relocate_bit <= MSR_RELOC_RST;
			st_r.data_relocate_bit <= MSR_RELOC_RST;
		end
		else if (CE)
			st_r <= st_nxt;
	end

	assign AVS_READDATA = st_r.rdata;
	assign ADDR_VALID = st_r.out_valid;
	assign ADDR_IS_FETCH = st_r.out_fetch;
	assign EFFECTIVE_ADDRESS = st_r.ea;
	assign VIRTUAL_ADDRESS = st_r.va;
	assign PHYSICAL_ADDRESS = st_r.pa;
	assign TRANSLATED = st_r.translated;
	assign TLB_MISS = st_r.miss;
	assign PRIV_FAULT = st_r.priv_fault;
	assign USER_MODE = st_r.user_mode_bit;
	assign FETCH_RELOCATE = st_r.fetch_relocate_bit;
	assign DATA_RELOCATE = st_r.data_relocate_bit;

	sequence fetch_req_s;
		CE && REQ_VALID && REQ_IS_FETCH && !REQ_PRIVILEGED;
	endsequence

	sequence data_req_s;
		CE && REQ_VALID && !REQ_IS_FETCH && !REQ_PRIVILEGED;
	endsequence

	seq_fetch_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		fetch_req_s and (FETCH_FORM == FF_SEQ) |=> EFFECTIVE_ADDRESS == $past(CURRENT_FETCH_ADDRESS) + 32'h4)
		else $error("sequential fetch address is not current plus four");

	branch_align_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		fetch_req_s and (FETCH_FORM != FF_SEQ) |=> EFFECTIVE_ADDRESS[1:0] == 2'h0)
		else $error("branch target not word aligned");

	link_target_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		fetch_req_s and (FETCH_FORM == FF_LINK) |=> EFFECTIVE_ADDRESS == ($past(LINK_RETURN_REGISTER) & 32'hFFFFFFFC))
		else $error("link register target wrong");

	zero_base_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		data_req_s and (DATA_FORM == DF_BASE) and (BASE_REG_FIELD == 5'h00) |=> EFFECTIVE_ADDRESS == 32'h0)
		else $error("zero base field did not give address zero");

	index_sum_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		data_req_s and (DATA_FORM == DF_BASE_INDEX) and (BASE_REG_FIELD != 5'h00)
		|=> EFFECTIVE_ADDRESS == 32'($past(BASE_REG_VALUE) + $past(INDEX_REG_VALUE)))
		else $error("base plus index sum wrong");

	imm_sext_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		data_req_s and (DATA_FORM == DF_BASE_IMM) and (BASE_REG_FIELD == 5'h00) and IMM_OFFSET[15]
		|=> EFFECTIVE_ADDRESS[31:16] == 16'hFFFF)
		else $error("negative offset not sign extended");

	real_fetch_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		fetch_req_s and !st_r.fetch_relocate_bit
		|=> ADDR_VALID && !TRANSLATED && PHYSICAL_ADDRESS == EFFECTIVE_ADDRESS)
		else $error("real mode fetch altered the address");

	data_mode_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		data_req_s |=> TRANSLATED == $past(st_r.data_relocate_bit))
		else $error("data access used the wrong relocate bit");

	priv_fault_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		CE && REQ_VALID && REQ_PRIVILEGED && USER_MODE |=> PRIV_FAULT && !ADDR_VALID && !TLB_MISS)
		else $error("privileged attempt in user mode not faulted");

	reset_priv_a: assert property (@(posedge SYS_CLK)
		RST |-> !USER_MODE)
		else $error("user mode bit not cleared by reset");

	miss_flag_a: assert property (@(posedge SYS_CLK) disable iff (RST)
		TLB_MISS |-> st_r.miss_sticky && !ADDR_VALID && st_r.miss_addr == EFFECTIVE_ADDRESS)
		else $error("translation miss not recorded");
endmodule

// ===== tb/eag_regfile_model.sv
// Register file model that answers base and index reads for the generator
`timescale 1ns/10ps
module eag_regfile_model
(
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [4:0] wr_sel,
	input wire logic [31:0] wr_data,
	input wire logic [4:0] base_sel,
	input wire logic [4:0] index_sel,
	output logic [31:0] base_value,
	output logic [31:0] index_value
);
	logic [31:0] regs_r [32];
	// Entry zero holds real data, so a generator that reads it as base gets caught
	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			regs_r[wr_sel] <= wr_data;
		end
	end
	assign base_value = regs_r[base_sel];
	assign index_value = regs_r[index_sel];
endmodule

// ===== tb/tb_top.sv
// Self-checking testbench of the effective address generator
`timescale 1ns/10ps
module tb_top;
	import eag_pkg::*;
	typedef struct packed {logic [2:0] k; logic [31:0] ea; logic [31:0] pa; logic [39:0] va; logic tr; logic f;} eag_exp_s;
	// Real page number of the single mapped page, value arbitrary
	localparam logic [21:0] RPN = 22'h2AB5C;
	logic SYS_CLK = 1'b0;
	logic RST = 1'b0;
	logic [7:0] AVS_ADDRESS = 8'h00;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h00000000;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic REQ_VALID = 1'b0;
	logic REQ_IS_FETCH = 1'b0;
	logic REQ_PRIVILEGED = 1'b0;
	eag_data_form_e DATA_FORM = DF_BASE;
	eag_fetch_form_e FETCH_FORM = FF_SEQ;
	logic [4:0] BASE_REG_FIELD = 5'h00;
	logic [4:0] idx_sel = 5'h00;
	logic [31:0] BASE_REG_VALUE;
	logic [31:0] INDEX_REG_VALUE;
	logic [15:0] IMM_OFFSET = 16'h0000;
	logic [25:0] BRANCH_DISP = 26'h0000000;
	logic [31:0] CURRENT_FETCH_ADDRESS = 32'h00000000;
	logic [31:0] LINK_RETURN_REGISTER = 32'h00000000;
	logic [31:0] LOOP_COUNT_REGISTER = 32'h00000000;
	logic ADDR_VALID, ADDR_IS_FETCH, TRANSLATED, TLB_MISS, PRIV_FAULT, USER_MODE, FETCH_RELOCATE, DATA_RELOCATE;
	logic [31:0] EFFECTIVE_ADDRESS;
	logic [31:0] PHYSICAL_ADDRESS;
	logic [39:0] VIRTUAL_ADDRESS;
	logic rf_we = 1'b0;
	logic [4:0] rf_sel = 5'h00;
	logic [31:0] rf_wd = 32'h00000000;
	logic [31:0] rf [32];
	logic m_f = 1'b0;
	logic m_d = 1'b0;
	logic m_u = 1'b0;
	logic [7:0] pid = 8'h00;
	logic [31:0] q;
	eag_exp_s expq [$];
	eag_exp_s got;
	int err_total = 0;
	int n_tests = 0;

	always #5 SYS_CLK = ~SYS_CLK;

	eag_top i_dut (.SYS_CLK(SYS_CLK), .RST(RST), .CE(1'b1), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .REQ_VALID(REQ_VALID), .REQ_IS_FETCH(REQ_IS_FETCH),
		.REQ_PRIVILEGED(REQ_PRIVILEGED), .DATA_FORM(DATA_FORM), .FETCH_FORM(FETCH_FORM),
		.BASE_REG_FIELD(BASE_REG_FIELD), .BASE_REG_VALUE(BASE_REG_VALUE), .INDEX_REG_VALUE(INDEX_REG_VALUE),
		.IMM_OFFSET(IMM_OFFSET), .BRANCH_DISP(BRANCH_DISP), .CURRENT_FETCH_ADDRESS(CURRENT_FETCH_ADDRESS),
		.LINK_RETURN_REGISTER(LINK_RETURN_REGISTER), .LOOP_COUNT_REGISTER(LOOP_COUNT_REGISTER),
		.ADDR_VALID(ADDR_VALID), .ADDR_IS_FETCH(ADDR_IS_FETCH), .EFFECTIVE_ADDRESS(EFFECTIVE_ADDRESS),
		.VIRTUAL_ADDRESS(VIRTUAL_ADDRESS), .PHYSICAL_ADDRESS(PHYSICAL_ADDRESS), .TRANSLATED(TRANSLATED),
		.TLB_MISS(TLB_MISS), .PRIV_FAULT(PRIV_FAULT), .USER_MODE(USER_MODE), .FETCH_RELOCATE(FETCH_RELOCATE),
		.DATA_RELOCATE(DATA_RELOCATE));

	eag_regfile_model i_regs (.clk(SYS_CLK), .wr_en(rf_we), .wr_sel(rf_sel), .wr_data(rf_wd),
		.base_sel(BASE_REG_FIELD), .index_sel(idx_sel), .base_value(BASE_REG_VALUE), .index_value(INDEX_REG_VALUE));

	task summarize();
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge SYS_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITE <= wr;
		AVS_READ <= ~wr;
		AVS_WRITEDATA <= d;
		// Read right after the edge, so waitrequest and read data are the values the design saw at it
		do
		begin
			@(posedge SYS_CLK);
			n++;
		end
		while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		if (n >= 50)
		begin
			chk(1'b0, "bus answer timeout");
			summarize();
		end
		rd = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask

	task machine_state_reg(input logic [2:0] v);
		bus(1'b1, 8'h00, {29'h00000000, v}, q);
		m_f = v[0];
		m_d = v[1];
		m_u = v[2];
		@(negedge SYS_CLK);
		chk({USER_MODE, DATA_RELOCATE, FETCH_RELOCATE} === v, "mode bits");
	endtask

	task req(input logic f, input logic pv, input logic [2:0] form, input logic [4:0] bf, input logic [4:0] xf,
		input logic [31:0] a, input logic [31:0] b);
		eag_exp_s e;
		logic [31:0] base;
		base = (bf == 5'h00) ? 32'h00000000 : rf[bf];
		if (f)
			case (form)
				3'h0: e.ea = a + 32'h00000004;
				3'h1: e.ea = (a + {{6{b[25]}}, b[25:0]}) & 32'hFFFFFFFC;
				3'h2: e.ea = {{6{b[25]}}, b[25:0]} & 32'hFFFFFFFC;
				3'h3: e.ea = b & 32'hFFFFFFFC;
				default: e.ea = ~b & 32'hFFFFFFFC;
			endcase
		else
			case (form)
				3'h0: e.ea = base;
				3'h1: e.ea = base + {{16{a[15]}}, a[15:0]};
				default: e.ea = base + rf[xf];
			endcase
		e.f = f;
		e.tr = f ? m_f : m_d;
		e.va = {pid, e.ea};
		e.pa = e.tr ? {RPN, e.ea[9:0]} : e.ea;
		if (m_u && pv)
			e.k = 3'b100;
		else if (e.tr && e.ea[31:10] != 22'h000000)
			e.k = 3'b010;
		else
			e.k = 3'b001;
		@(posedge SYS_CLK);
		REQ_VALID <= 1'b1;
		REQ_IS_FETCH <= f;
		REQ_PRIVILEGED <= pv;
		DATA_FORM <= eag_data_form_e'(form[1:0]);
		FETCH_FORM <= eag_fetch_form_e'(form);
		BASE_REG_FIELD <= bf;
		idx_sel <= xf;
		IMM_OFFSET <= a[15:0];
		BRANCH_DISP <= b[25:0];
		CURRENT_FETCH_ADDRESS <= a;
		LINK_RETURN_REGISTER <= b;
		LOOP_COUNT_REGISTER <= ~b;
		expq.push_back(e);
	endtask

	task idle();
		@(posedge SYS_CLK);
		REQ_VALID <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
	endtask

	always @(negedge SYS_CLK)
	begin
		if (RST === 1'b0 && (ADDR_VALID === 1'b1 || TLB_MISS === 1'b1 || PRIV_FAULT === 1'b1))
		begin
			if (expq.size() == 0)
				chk(1'b0, "result without request");
			else
			begin
				got = expq.pop_front();
				chk({PRIV_FAULT, TLB_MISS, ADDR_VALID} === got.k, "result kind");
				if (got.k != 3'b100)
					chk(EFFECTIVE_ADDRESS === got.ea, "effective address");
				if (got.k == 3'b001)
				begin
					chk(PHYSICAL_ADDRESS === got.pa, "physical address");
					chk(VIRTUAL_ADDRESS === got.va, "virtual address");
					chk({TRANSLATED, ADDR_IS_FETCH} === {got.tr, got.f}, "mode of access");
				end
			end
		end
	end

	initial
	begin
		repeat (20000) @(posedge SYS_CLK);
		chk(1'b0, "run timeout");
		summarize();
	end

	initial
	begin
		void'($urandom(86));
		// Raised by a nonblocking assignment at time zero so the asynchronous reset sees a real rising edge
		RST <= 1'b1;
		repeat (3) @(posedge SYS_CLK);
		RST <= 1'b0;
		@(negedge SYS_CLK);
		chk({USER_MODE, DATA_RELOCATE, FETCH_RELOCATE} === 3'b000, "mode after reset");
		bus(1'b0, 8'h00, 32'h00000000, q);
		chk(q === 32'h00000000, "mode register reset");
		for (int i = 0; i < 32; i++)
		begin
			@(posedge SYS_CLK);
			rf[i] = (i == 31) ? 32'hFFFFFFF0 : $urandom();
			rf_we <= 1'b1;
			rf_sel <= 5'(i);
			rf_wd <= rf[i];
		end
		@(posedge SYS_CLK);
		rf_we <= 1'b0;
		for (int n = 0; n < 80; n++)
			req(n[0], n[1], n[0] ? 3'($urandom_range(0, 4)) : 3'($urandom_range(0, 2)),
				(n % 4 == 0) ? 5'h00 : 5'($urandom()), 5'($urandom()), $urandom(), $urandom());
		req(1'b1, 1'b0, 3'h0, 5'h00, 5'h00, 32'hFFFFFFFC, 32'h00000000);
		req(1'b0, 1'b0, 3'h1, 5'h1F, 5'h00, 32'h00000020, 32'h00000000);
		req(1'b1, 1'b0, 3'h3, 5'h00, 5'h00, 32'h00000000, 32'h00000123);
		req(1'b1, 1'b0, 3'h4, 5'h00, 5'h00, 32'h00000000, 32'h00000123);
		idle();
		// Software loads one translation for page zero
		bus(1'b1, 8'h08, 32'h00000000, q);
		bus(1'b1, 8'h0C, 32'h80000000, q);
		bus(1'b1, 8'h10, {10'h000, RPN}, q);
		bus(1'b1, 8'h04, 32'h0000005A, q);
		pid = 8'h5A;
		bus(1'b0, 8'h18, 32'h00000000, q);
		chk(q === {10'h000, RPN}, "entry read back");
		bus(1'b0, 8'h14, 32'h00000000, q);
		chk(q === 32'h80000000, "entry tag read back");
		for (int m = 0; m < 4; m++)
		begin
			machine_state_reg(3'(m));
			req(1'b0, 1'b0, 3'h1, 5'h00, 5'h00, 32'h00000120, 32'h00000000);
			req(1'b1, 1'b0, 3'h0, 5'h00, 5'h00, 32'h00000200, 32'h00000000);
			req(1'b1, 1'b0, 3'h0, 5'h00, 5'h00, 32'h12340000, 32'h00000000);
			idle();
		end
		bus(1'b0, 8'h20, 32'h00000000, q);
		chk(q === 32'h12340004, "miss address");
		machine_state_reg(3'h4);
		req(1'b0, 1'b1, 3'h0, 5'h00, 5'h00, 32'h00000000, 32'h00000000);
		req(1'b0, 1'b0, 3'h0, 5'h00, 5'h00, 32'h00000000, 32'h00000000);
		idle();
		bus(1'b0, 8'h1C, 32'h00000000, q);
		chk(q === 32'h00000003, "fault and miss status");
		bus(1'b1, 8'h1C, 32'h00000003, q);
		bus(1'b0, 8'h1C, 32'h00000000, q);
		chk(q === 32'h00000000, "status cleared");
		machine_state_reg(3'h0);
		req(1'b1, 1'b1, 3'h0, 5'h00, 5'h00, 32'h00000400, 32'h00000000);
		idle();
		bus(1'b0, 8'hFC, 32'h00000000, q);
		chk(q === 32'h00000000, "unmapped read");
		repeat (3) @(posedge SYS_CLK);
		chk(expq.size() == 0, "missing results");
		summarize();
	end
endmodule
